// >>> hdl/qbx_dev.sv
// device end: serial slave, latched quasi-bidirectional port, change line
//
// Functional notes
// RL1: host writes one to input pins
// RL2: output pins hold last written level
// RL3: read returns actual pin levels
// RL4: change line reports port changes
// RL5: host waits for low, then reads
// RL6: write is start, addr, ack, data, ack, stop
// RL7: data bit n controls pin n
// RL8: read is start, addr, ack, data, nack, stop
// RL9: rewrites keep input bits at one
// RL10: tied pins switch together
// RL11: change asserts on edge, clears on restore/access
// RL12: read clears change at address ack
// RL13: reset gives inputs high, low pin flags
// RL14: read bit one, data until nack
// RL15: latched port register, reset all ones
module qbx_dev (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // link
  qbx_if.dev                              lnk,
  // port pins: input, output, enable (low drives low)
  input  wire logic [qbx_pkg::PORT_W-1:0] port_in,
  output logic      [qbx_pkg::PORT_W-1:0] port_out,
  output logic      [qbx_pkg::PORT_W-1:0] port_oe_n
);
  import qbx_pkg::*;

  // the device acts one clock after the scl edge it sees; the host's
  // half period is many clocks long, so sda moves well inside scl low

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    QBX_IDLE, QBX_ADDR, QBX_WDATA, QBX_RDATA, QBX_IGNORE
  } qbx_st_e;

  // all state in one packed struct; the comb copy is registered whole
  typedef struct packed {
    qbx_st_e            st;       // protocol phase
    logic               scl;      // previous scl
    logic               sda;      // previous sda
    logic [3:0]         bitn;     // bit index in byte, 8 = ack slot
    logic [7:0]         sh;       // shift register
    logic               rd;       // current transfer reads
    logic               armed;    // a clock rise seen since start
    logic               resnap;   // retake snapshot once pins settle
    logic [PORT_W-1:0]  port;     // latched port register
    logic [PORT_W-1:0]  snap;     // last pin levels seen by host
    logic               sda_o;    // sda output level
    logic               sda_oe_n; // sda enable
    logic               chg_oe_n; // change line enable
  } qbx_dev_s;

  qbx_dev_s s_q, s_d;
  logic     rise, fall, start, stop; // link events

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one pass decides the next state; sda is driven on scl falls and released at start or stop
  always_comb begin
    s_d   = s_q;
    s_d.scl = lnk.scl_o;
    s_d.sda = lnk.sda;
    rise  = lnk.scl_o & ~s_q.scl;
    fall  = ~lnk.scl_o & s_q.scl;
    start = lnk.scl_o & s_q.scl & s_q.sda & ~lnk.sda;
    stop  = lnk.scl_o & s_q.scl & ~s_q.sda & lnk.sda;
    // change flag: pins differ from the snapshot the host last saw
    s_d.chg_oe_n = (port_in == s_q.snap);                     // [RL4] [RL11]
    s_d.resnap   = 1'b0;
    // a write moves the pins one clock after the latch; taking the
    // baseline again then keeps the host's own write from raising a
    // change, while an outside edge after that still does
    if (s_q.resnap) begin
      s_d.snap     = port_in;                                  // [RL11]
      s_d.chg_oe_n = 1'b1;
    end
    if (start) begin
      s_d.st   = QBX_ADDR;
      s_d.bitn = BIT_ZERO;
      s_d.armed = 1'b0;  // the fall that ends a start is no bit
      s_d.sda_oe_n = 1'b1;
    end else if (stop) begin
      // a stop ends any transfer; a cut frame leaves the port untouched
      s_d.st   = QBX_IDLE;
      s_d.sda_oe_n = 1'b1;
    end else if (rise) begin
      // sample on rising scl
      s_d.armed = 1'b1;
      case (s_q.st)
        QBX_ADDR, QBX_WDATA: begin
          if (s_q.bitn <= BIT_LAST)
            s_d.sh = {s_q.sh[6:0], lnk.sda};
        end
        QBX_RDATA: begin
          // host nack at ack slot ends the read
          if (s_q.bitn == BIT_ACK && lnk.sda)                 // [RL8] [RL14]
            s_d.st = QBX_IGNORE;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      // advance and drive on falling scl
      case (s_q.st)
        // the first fall after a start only closes the start and must
        // not count as a bit, or the address is checked one bit early
        QBX_ADDR: if (s_q.armed) begin
          if (s_q.bitn == BIT_LAST) begin
            if (s_q.sh[7:1] == DEV_ADDR) begin
              s_d.sda_o    = 1'b0;                            // [RL6]
              s_d.sda_oe_n = 1'b0;
              s_d.rd       = s_q.sh[0];
              if (s_q.sh[0]) begin
                s_d.snap     = port_in;                       // [RL12]
                s_d.chg_oe_n = 1'b1;
              end
              s_d.bitn = BIT_ACK;
            end else
              s_d.st = QBX_IGNORE;
          end else if (s_q.bitn == BIT_ACK) begin
            s_d.bitn = BIT_ZERO;
            if (s_q.rd) begin
              s_d.st       = QBX_RDATA;
              s_d.sh       = port_in;                          // [RL3]
              s_d.sda_o    = port_in[7];
              s_d.sda_oe_n = port_in[7];
            end else begin
              s_d.st       = QBX_WDATA;
              s_d.sda_oe_n = 1'b1;
            end
          end else
            s_d.bitn = s_q.bitn + 4'h0_1;
        end
        QBX_WDATA: begin
          if (s_q.bitn == BIT_LAST) begin
            s_d.port     = s_q.sh;                             // [RL15] [RL7]
            s_d.resnap   = 1'b1;                               // [RL11]
            s_d.snap     = port_in;                            // [RL11]
            s_d.chg_oe_n = 1'b1;
            s_d.sda_o    = 1'b0;                               // [RL6]
            s_d.sda_oe_n = 1'b0;
            s_d.bitn     = BIT_ACK;
          end else if (s_q.bitn == BIT_ACK) begin
            s_d.sda_oe_n = 1'b1;
            s_d.bitn     = BIT_ZERO;
          end else
            s_d.bitn = s_q.bitn + 4'h0_1;
        end
        QBX_RDATA: begin
          if (s_q.bitn == BIT_LAST) begin
            s_d.sda_oe_n = 1'b1;                 // release for host ack
            s_d.bitn     = BIT_ACK;
          end else if (s_q.bitn == BIT_ACK) begin
            // host acked: send a fresh sample
            s_d.sh       = port_in;                            // [RL3]
            s_d.snap     = port_in;                            // [RL12]
            s_d.chg_oe_n = 1'b1;
            s_d.sda_o    = port_in[7];
            s_d.sda_oe_n = port_in[7];
            s_d.bitn     = BIT_ZERO;
          end else begin
            s_d.sh       = {s_q.sh[6:0], 1'b1};
            s_d.sda_o    = s_q.sh[6];
            s_d.sda_oe_n = s_q.sh[6];
            s_d.bitn     = s_q.bitn + 4'h0_1;
          end
        end
        default: begin
        end
      endcase
    end
    // reset last so it overrides every link event of the same clock
    if (reset) begin
      s_d          = '0;
      s_d.st       = QBX_IDLE;
      s_d.scl      = 1'b1;
      s_d.sda      = 1'b1;
      s_d.port     = PORT_RST;                                 // [RL13]
      s_d.snap     = PORT_RST;     // low pin then flags change [RL13]
      s_d.sda_o    = 1'b1;
      s_d.sda_oe_n = 1'b1;
      s_d.chg_oe_n = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one register set holds all state; reset is folded in above
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // outputs straight from flops; a one bit only releases the pin
  // limitation: a pin written low reads low whatever drives it outside
  assign port_out       = s_q.port;                            // [RL2]
  assign port_oe_n      = s_q.port;                            // [RL2]
  assign lnk.sda_d_o    = s_q.sda_o;
  assign lnk.sda_d_oe_n = s_q.sda_oe_n;
  assign lnk.chg_oe_n   = s_q.chg_oe_n;
endmodule : qbx_dev

// >>> shared/qbx_pkg.sv
// package: shared constants for the quasi-bidirectional expander
package qbx_pkg;
  localparam int          PORT_W     = 8;             // port width
  localparam logic [7:0]  PORT_RST   = 8'h00_FF;      // all pins high
  localparam logic [6:0]  DEV_ADDR   = 7'h00_20;      // slave address
  localparam logic [3:0]  BIT_LAST   = 4'h0_7;        // last bit of a byte
  localparam logic [3:0]  BIT_ACK    = 4'h0_8;        // ack slot index
  localparam logic [3:0]  BIT_ZERO   = 4'h0_0;        // first bit index
  localparam int          SCL_HALF   = 20;            // host half period
  localparam logic [7:0]  HALF_CNT   = 8'h00_14;      // same, as count
  localparam logic [7:0]  CNT_ZERO   = 8'h00_00;      // counter clear
endpackage : qbx_pkg

// >>> shared/qbx_if.sv
// interface: two-wire link plus change line between host and expander
interface qbx_if;
  logic scl_o;      // clock driven by host
  logic sda_h_o;    // host sda level
  logic sda_h_oe_n; // host sda enable, low drives
  logic sda_d_o;    // device sda level
  logic sda_d_oe_n; // device sda enable, low drives
  logic chg_oe_n;   // device change line enable, low pulls low
  logic sda;        // resolved sda
  logic chg_n;      // resolved change line
  assign sda   = (~sda_h_oe_n & ~sda_h_o) | (~sda_d_oe_n & ~sda_d_o)
                 ? 1'b0 : 1'b1;
  assign chg_n = ~chg_oe_n ? 1'b0 : 1'b1;
  modport dev  (input scl_o, input sda, output sda_d_o, output sda_d_oe_n,
                output chg_oe_n);
  modport host (output scl_o, output sda_h_o, output sda_h_oe_n,
                input sda, input chg_n);
endinterface : qbx_if

// >>> hdl/qbx_host.sv
// host end: bit-level master issuing one-byte port writes and reads
module qbx_host (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // link
  qbx_if.host             lnk,
  // user command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            done,
  output logic      [7:0] rdata,
  output logic            nacked,
  output logic            change
);
  import qbx_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    QBH_IDLE, QBH_START, QBH_BITS, QBH_STOP, QBH_END
  } qbh_st_e;

  typedef struct packed {
    qbh_st_e    st;
    logic [7:0] cnt;    // half period timer
    logic       ph;     // 0 scl low half, 1 high half
    logic [4:0] bitn;   // bit over both bytes incl ack slots
    logic [7:0] sh;     // outgoing byte
    logic [7:0] rx;     // incoming byte
    logic       rd;
    logic       scl;
    logic       sda;    // 1 releases
    logic       ready;
    logic       done;
    logic       nack;
    logic       chg;
  } qbh_s;

  qbh_s s_q, s_d;
  logic tick;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.chg  = ~lnk.chg_n;                                      // [RL5]
    tick     = (s_q.cnt == HALF_CNT);
    s_d.cnt  = tick ? CNT_ZERO : s_q.cnt + 8'h00_01;
    case (s_q.st)
      QBH_IDLE: begin
        s_d.cnt = CNT_ZERO;
        if (cmd_valid & s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.rd    = cmd_read;
          s_d.sh    = {DEV_ADDR, cmd_read};                    // [RL14]
          s_d.rx    = cmd_wdata;   // parked write byte
          s_d.nack  = 1'b0;
          s_d.st    = QBH_START;
        end
      end
      QBH_START: if (tick) begin
        s_d.sda  = 1'b0;                       // start: sda falls, scl high
        s_d.st   = QBH_BITS;
        s_d.bitn = 5'h0_0;
        s_d.ph   = 1'b1;
      end
      QBH_BITS: if (tick) begin
        if (s_q.ph) begin
          // end of high half: pull scl low, put next bit
          s_d.scl = 1'b0;
          s_d.ph  = 1'b0;
          if (s_q.bitn == 5'h1_2) begin
            s_d.sda = 1'b0;
            s_d.st  = QBH_STOP;
          end else if (s_q.bitn == 5'h0_8) begin
            s_d.sda = 1'b1;                                    // slave acks
          end else if (s_q.bitn == 5'h1_1) begin
            s_d.sda = 1'b1;   // read: nack with one [RL8]; write: release
          end else if (s_q.bitn > 5'h0_8 && s_q.rd) begin
            s_d.sda = 1'b1;
          end else begin
            s_d.sda = s_q.sh[7];                               // [RL6]
            s_d.sh  = {s_q.sh[6:0], 1'b1};
          end
          s_d.bitn = s_q.bitn + 5'h0_1;
        end else begin
          // end of low half: raise scl and sample
          s_d.scl = 1'b1;
          s_d.ph  = 1'b1;
          if (s_q.bitn == 5'h0_9) begin
            if (lnk.sda) begin
              s_d.nack = 1'b1;
              s_d.bitn = 5'h1_2;
            end
            s_d.sh = s_q.rx;     // load data byte for writes [RL1] [RL9]
          end else if (s_q.bitn == 5'h1_2 && !s_q.rd && lnk.sda)
            s_d.nack = 1'b1;
          else if (s_q.bitn > 5'h0_9 && s_q.bitn < 5'h1_2 && s_q.rd)
            s_d.rx = {s_q.rx[6:0], lnk.sda};
        end
      end
      QBH_STOP: if (tick) begin
        if (!s_q.scl)
          s_d.scl = 1'b1;
        else begin
          s_d.sda = 1'b1;                       // stop: sda rises, scl high
          s_d.st  = QBH_END;
        end
      end
      QBH_END: if (tick) begin
        s_d.done  = 1'b1;
        s_d.ready = 1'b1;
        s_d.st    = QBH_IDLE;
      end
      default: s_d.st = QBH_IDLE;
    endcase
    if (reset) begin
      s_d       = '0;
      s_d.st    = QBH_IDLE;
      s_d.scl   = 1'b1;
      s_d.sda   = 1'b1;
      s_d.ready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // outputs from flops, host sda level tied low; RL10 is the user's job: tied pins share bits
  assign lnk.scl_o      = s_q.scl;
  assign lnk.sda_h_o    = 1'b0;
  assign lnk.sda_h_oe_n = s_q.sda;
  assign cmd_ready      = s_q.ready;
  assign done           = s_q.done;
  assign rdata          = s_q.rx;
  assign nacked         = s_q.nack;
  assign change         = s_q.chg;
endmodule : qbx_host

// >>> sim/qbx_monitor.sv
// checker: link, change line and port relations of the expander pair
module qbx_monitor (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // link
  input wire logic       scl_o,
  input wire logic       sda,
  input wire logic       sda_d_o,
  input wire logic       sda_d_oe_n,
  input wire logic       chg_n,
  // port pins
  input wire logic [7:0] port_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // bus is idle once reset lets go
  idle_after_rst_a: assert property ($fell(reset) |-> scl_o && sda)
    else $error("link not idle after reset");
  // a pin held low out of reset flags a change
  rst_flag_a: assert property (
    $fell(reset) && port_in != 8'hff |-> ##[0:2] !chg_n)
    else $error("low pin after reset not flagged");
  // the port register only loads as the device acks a data byte
  port_ack_a: assert property (
    $changed(port_out) |-> !sda_d_oe_n && !sda_d_o)
    else $error("port register loaded without a data ack");
  // port register only loads after a clock fall
  port_hold_a: assert property ($changed(port_out) |-> !scl_o)
    else $error("port register moved outside a write");
  // no pin activity and no bus edges: change line keeps still
  chg_quiet_a: assert property (
    ($stable(port_in) && $stable(scl_o))[*6] |-> $stable(chg_n))
    else $error("change line moved without cause");
  // device only starts driving with the clock low
  dev_ack_low_a: assert property ($fell(sda_d_oe_n) |-> !scl_o)
    else $error("device took sda with clock high");
  // device data stays put while the clock is high
  dev_sda_hold_a: assert property (
    scl_o && $past(scl_o) |-> $stable(sda_d_oe_n | sda_d_o))
    else $error("device sda moved with clock high");
  // device never holds sda past ack plus one byte
  dev_release_a: assert property (!sda_d_oe_n |-> ##[1:420] sda_d_oe_n)
    else $error("device held sda too long");
  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  cover property ($fell(chg_n));
  cover property ($rose(chg_n));
  cover property ($changed(port_out));
  cover property ($fell(sda_d_oe_n));
endmodule : qbx_monitor

// >>> sim/qbx_tb.sv
// testbench: host and device ends joined over the link
module qbx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qbx_pkg::*;
  logic       mclk, reset, cmd_valid, cmd_read, cmd_ready, done;
  logic       nacked, change;
  logic [7:0] cmd_wdata, rdata, ext, port_in, port_out, port_oe_n, w;
  int         n_mismatch, checks_done, cyc;
  // one compare, counted, mismatch printed at once
  `define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin \
    n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); \
    end end
  // ------------------------------------------------------------
  // structure
  // ------------------------------------------------------------
  qbx_if lnk ();
  // quasi pins: outside driver wired-and with the device pull-down
  assign port_in = ext & port_oe_n;
  qbx_dev u_qbx_dev (.mclk, .reset, .lnk(lnk), .port_in, .port_out,
    .port_oe_n);
  qbx_host u_qbx_host (.mclk, .reset, .lnk(lnk), .cmd_valid, .cmd_read,
    .cmd_wdata, .cmd_ready, .done, .rdata, .nacked, .change);
  qbx_monitor u_qbx_monitor (.mclk, .reset, .scl_o(lnk.scl_o),
    .sda(lnk.sda), .sda_d_o(lnk.sda_d_o), .sda_d_oe_n(lnk.sda_d_oe_n),
    .chg_n(lnk.chg_n), .port_in, .port_out, .port_oe_n);
  // ------------------------------------------------------------
  // clock, hang guard, tasks
  // ------------------------------------------------------------
  always #12.5 mclk = ~mclk;
  // 18 transfers of about 860 cycles each; about two and a half times that as ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // quasi pin level: a pin reads high only if released and driven high
  function automatic logic [7:0] exp_pins(input logic [7:0] port,
                                          input logic [7:0] outside);
    return port & outside;
  endfunction : exp_pins
  // let n edges pass, then settle just after the last
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : idle
  task automatic do_reset();
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
  endtask : do_reset
  // one byte transfer; request held until the edge that takes it
  task automatic xfer(input logic rd, input logic [7:0] d);
    logic ok;
    cmd_read = rd;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    do begin
      ok = cmd_ready;
      idle(1);
    end while (ok !== 1'b1);
    cmd_valid = 1'b0;
    while (done !== 1'b1) idle(1);
  endtask : xfer
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_wdata = 8'h00;
    ext = 8'hff;
    void'($urandom(32'hc21d));
    do_reset();
    `CHK(port_out, 8'hff)
    `CHK(lnk.chg_n, 1'b1)
    // pin zero pulled low across a second reset
    ext = 8'hfe;
    do_reset();
    idle(3);
    `CHK(lnk.chg_n, 1'b0)
    xfer(1'b0, 8'ha3);
    `CHK(port_out, 8'ha3)
    `CHK(nacked, 1'b0)
    `CHK(lnk.chg_n, 1'b1)
    // edge, restore, edge again
    ext = 8'hff;
    idle(3);
    `CHK(lnk.chg_n, 1'b0)
    ext = 8'hfe;
    idle(3);
    `CHK(lnk.chg_n, 1'b1)
    ext = 8'hff;
    idle(3);
    `CHK(change, 1'b1)
    xfer(1'b1, 8'h00);
    `CHK(rdata, 8'ha3)
    `CHK(lnk.chg_n, 1'b1)
    // update value first, then random outputs with inputs kept high
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 8'h2b : 8'($urandom);
      w[1:0] = 2'b11;
      w[6] = w[7];
      ext = 8'($urandom);
      xfer(1'b0, w);
      `CHK(port_out, w)
      `CHK(port_oe_n, w)
      xfer(1'b1, 8'h00);
      `CHK(rdata, exp_pins(w, ext))
      `CHK(nacked, 1'b0)
    end
    report_and_stop();
  end
endmodule : qbx_tb
